// >>> accel_regs_pkg.sv
package accel_regs_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_RATE       = 8'h08;
  localparam logic [7:0] ADDR_MOTION     = 8'h09;
  localparam logic [7:0] ADDR_FIFO_FLAGS = 8'h0A;
  localparam logic [7:0] ADDR_FIFO_READ  = 8'h0B;
  localparam logic [7:0] ADDR_X_LOW      = 8'h0D;
  localparam logic [7:0] ADDR_Z_HIGH     = 8'h12;

  localparam logic [7:0] RATE_RESET      = 8'h00;
  localparam logic [7:0] MOTION_RESET    = 8'h00;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // ---------------------------------------------------------------
  // Field layouts
  // ---------------------------------------------------------------
  localparam int RATE_W      = 3;
  localparam int MOT_TILT_ON = 0;
  localparam int MOT_HOLD    = 1;
  localparam int MOT_ANY_ON  = 2;
  localparam int MOT_SHAKE   = 3;
  localparam int MOT_T35     = 4;
  localparam int MOT_ZPOL    = 5;
  localparam int MOT_RAW     = 6;
  localparam int MOT_BLKRST  = 7;

  localparam int FLAG_EMPTY  = 0;
  localparam int FLAG_FULL   = 1;
  localparam int FLAG_LEVEL  = 2;

  // Motion detector flag order.
  localparam int MF_TILT     = 0;
  localparam int MF_FLIP     = 1;
  localparam int MF_ANY      = 2;
  localparam int MF_SHAKE    = 3;
  localparam int MF_T35      = 4;
  localparam int MF_COUNT    = 5;

  // ---------------------------------------------------------------
  // Queue geometry and timing
  // ---------------------------------------------------------------
  localparam int PTR_W          = 6;
  localparam int QADDR_W        = 5;
  localparam int QUEUE_DEPTH    = 32;
  localparam int LEVEL_DEFAULT  = 16;
  localparam int DEBOUNCE_TICKS = 3;
  localparam int CLOCK_HZ       = 100_000_000;

  // Read sequence tracker for the X-to-Z output burst.
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_ARMED = 2'b01
  } read_seq_t;

  // Output data rate in Hz for each rate code.
  function automatic int rate_hz(input logic [RATE_W-1:0] sel);
    case (sel)
      3'h0:    rate_hz = 50;
      3'h1:    rate_hz = 100;
      3'h2:    rate_hz = 125;
      3'h3:    rate_hz = 200;
      3'h4:    rate_hz = 250;
      3'h5:    rate_hz = 500;
      3'h6:    rate_hz = 1000;
      default: rate_hz = 2000;
    endcase
  endfunction

endpackage

// >>> queue_ptr_if.sv
`timescale 1ns/1ps
// Signals between the register bank and the queue pointer logic.
interface queue_ptr_if;
  import accel_regs_pkg::*;
  logic             push;
  logic             pop;
  logic             empty;
  logic             full;
  logic             level_hit;
  logic [PTR_W-1:0] queue_read_index;
  logic [PTR_W-1:0] queue_write_index;

  modport ctrl (output push, output pop, input empty, input full,
                input level_hit, input queue_read_index,
                input queue_write_index);
  modport ptrs (input push, input pop, output empty, output full,
                output level_hit, output queue_read_index,
                output queue_write_index);
endinterface

// >>> queue_pointers.sv
`timescale 1ns/1ps
module queue_pointers
#(
  parameter int LEVEL = accel_regs_pkg::LEVEL_DEFAULT
)
(
  input  wire logic      clock_in,
  input  wire logic      rst_in,
  queue_ptr_if.ptrs      q
);
  import accel_regs_pkg::*;

  logic [PTR_W-1:0] rd_r;
  logic [PTR_W-1:0] rd_nxt;
  logic [PTR_W-1:0] wr_r;
  logic [PTR_W-1:0] wr_nxt;
  logic [PTR_W-1:0] fill;

  // Number of stored samples from the two wrapping pointers.
  function automatic logic [PTR_W-1:0] fill_of(
    input logic [PTR_W-1:0] w, input logic [PTR_W-1:0] r);
    fill_of = w - r;
  endfunction

  // ---------------------------------------------------------------
  // Live flags
  // ---------------------------------------------------------------
  // Flags are combinational so a read always sees the present state.
  assign fill        = fill_of(wr_r, rd_r);
  assign q.empty     = (wr_r == rd_r);
  assign q.full      = (wr_r[QADDR_W-1:0] == rd_r[QADDR_W-1:0]) &&
                       (wr_r[PTR_W-1] != rd_r[PTR_W-1]);
  assign q.level_hit = (fill >= PTR_W'(LEVEL));
  assign q.queue_read_index  = rd_r;
  assign q.queue_write_index = wr_r;

  // ---------------------------------------------------------------
  // Pointer update
  // ---------------------------------------------------------------
  // A full queue takes no further sample and an empty one no pop.
  always_comb
  begin
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    if (q.push && !q.full)
      wr_nxt = wr_r + PTR_W'(1);
    if (q.pop && !q.empty)
      rd_nxt = rd_r + PTR_W'(1);
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_r <= '0;
      wr_r <= '0;
    end
    else
    begin
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
    end
  end

endmodule

// >>> accel_rate_motion_fifo_regs.sv
`timescale 1ns/1ps
// Functional notes
// - Rate field bits 2:0 pick 50 to 2000 Hz; internal rate equals it.
// - Rate register also sets the main oscillator frequency.
// - Tilt/flip enable gates that feature and its flags; off by default.
// - Hold bit set makes the motion block latch its outputs.
// - Any-motion enable turns on any-motion and permits shake, tilt-35.
// - Z polarity bit: 0 positive through top, 1 through bottom.
// - Unfiltered bit selects raw flags instead of debounced ones.
// - Block reset bit holds motion block in reset; never self-clears.
// - Queue flag register returns live flags, independent of IRQ enables.
// - Empty flag bit 0 is one while the queue holds nothing.
// - Full flag bit 1 is one when queue is full; zero at reset.
// - Level flag bit 2 set when fill reaches threshold, default 16.
// - Queue flag register bits 7:3 read as zero.
// - Read index is 6 bits: 5-bit address plus a wrap bit.
// - Read index register bits 7:6 read as zero.
// - Write index advances on each sample whose Z data was captured while the queue is not full.
module accel_rate_motion_fifo_regs
#(
  parameter int CLK_HZ    = accel_regs_pkg::CLOCK_HZ,
  parameter int LEVEL     = accel_regs_pkg::LEVEL_DEFAULT,
  parameter int DEBOUNCE  = accel_regs_pkg::DEBOUNCE_TICKS
)
(
  input  wire logic                                 clock_in,
  input  wire logic                                 rst_in,
  input  wire logic [7:0]                           reg_addr_in,
  input  wire logic                                 reg_wr_in,
  input  wire logic [7:0]                           reg_wdata_in,
  input  wire logic                                 reg_rd_in,
  output logic      [7:0]                           reg_rdata_out,
  input  wire logic                                 sample_valid_in,
  input  wire logic                                 z_captured_in,
  input  wire logic [accel_regs_pkg::MF_COUNT-1:0]  motion_raw_in,
  output logic      [accel_regs_pkg::RATE_W-1:0]    osc_select_out,
  output logic                                      sample_tick_out,
  output logic      [accel_regs_pkg::MF_COUNT-1:0]  motion_flags_out,
  output logic                                      motion_reset_out,
  output logic                                      z_polarity_select_out,
  output logic      [accel_regs_pkg::PTR_W-1:0]     queue_write_index_out
);
  import accel_regs_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0]          rate_r;
  logic [7:0]          rate_nxt;
  logic [7:0]          motion_r;
  logic [7:0]          motion_nxt;
  logic [7:0]          rdata_r;
  logic [7:0]          rdata_nxt;
  read_seq_t           seq_r;
  read_seq_t           seq_nxt;
  logic [31:0]         div_cnt_r;
  logic [31:0]         div_cnt_nxt;
  logic [31:0]         div_top;
  logic                tick_r;
  logic                tick_nxt;
  logic [MF_COUNT-1:0] feat_on;
  logic [MF_COUNT-1:0] gated_raw;
  logic [MF_COUNT-1:0] filtered;
  logic [MF_COUNT-1:0] chosen;
  logic [MF_COUNT-1:0] flags_r;
  logic [MF_COUNT-1:0] flags_nxt;
  logic [7:0]          db_cnt_r   [MF_COUNT];
  logic [7:0]          db_cnt_nxt [MF_COUNT];
  logic [7:0]          db_limit;
  logic                rd_hit_low;
  logic                rd_hit_high;
  logic                rd_in_burst;
  logic                block_reset;

  queue_ptr_if qif ();

  // Register write decode.
  function automatic logic wr_hit(input logic [7:0] a,
                                  input logic [7:0] target,
                                  input logic       we);
    wr_hit = we && (a == target);
  endfunction

  // ---------------------------------------------------------------
  // Queue pointers
  // ---------------------------------------------------------------
  queue_pointers #(
    .LEVEL    (LEVEL)
  ) u_queue (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .q        (qif.ptrs)
  );

  // A sample enters the queue only once its Z data is in.
  assign qif.push = sample_valid_in && z_captured_in;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Both registers store the full written byte; the host keeps the
  // fixed bits of the rate register as expected, the hardware only
  // uses the rate field.
  always_comb
  begin
    rate_nxt   = rate_r;
    motion_nxt = motion_r;
    if (wr_hit(reg_addr_in, ADDR_RATE, reg_wr_in))
      rate_nxt = reg_wdata_in;
    if (wr_hit(reg_addr_in, ADDR_MOTION, reg_wr_in))
      motion_nxt = reg_wdata_in;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rate_r   <= RATE_RESET;
      motion_r <= MOTION_RESET;
    end
    else
    begin
      rate_r   <= rate_nxt;
      motion_r <= motion_nxt;
    end
  end

  // Control decode shared by the motion path.
  assign block_reset           = motion_r[MOT_BLKRST];
  assign motion_reset_out      = block_reset;
  assign z_polarity_select_out = motion_r[MOT_ZPOL];
  assign osc_select_out        = rate_r[RATE_W-1:0];
  assign queue_write_index_out = qif.queue_write_index;

  // ---------------------------------------------------------------
  // Sample rate divider
  // ---------------------------------------------------------------
  // Cycles per sample at the chosen output rate; the internal rate
  // is the same, so one tick serves both.
  assign div_top = 32'(CLK_HZ / rate_hz(rate_r[RATE_W-1:0]))
                   - 32'h0000_0001;

  always_comb
  begin
    tick_nxt    = 1'b0;
    div_cnt_nxt = div_cnt_r + 32'h0000_0001;
    if (div_cnt_r >= div_top)
    begin
      div_cnt_nxt = '0;
      tick_nxt    = 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_cnt_r <= '0;
      tick_r    <= 1'b0;
    end
    else
    begin
      div_cnt_r <= div_cnt_nxt;
      tick_r    <= tick_nxt;
    end
  end

  assign sample_tick_out = tick_r;

  // ---------------------------------------------------------------
  // Motion feature gating
  // ---------------------------------------------------------------
  // Shake and tilt-35 need any-motion as well as their own enable.
  always_comb
  begin
    feat_on           = '0;
    feat_on[MF_TILT]  = motion_r[MOT_TILT_ON];
    feat_on[MF_FLIP]  = motion_r[MOT_TILT_ON];
    feat_on[MF_ANY]   = motion_r[MOT_ANY_ON];
    feat_on[MF_SHAKE] = motion_r[MOT_SHAKE] &&
                        motion_r[MOT_ANY_ON];
    feat_on[MF_T35]   = motion_r[MOT_T35] &&
                        motion_r[MOT_ANY_ON];
  end

  assign gated_raw = block_reset ? '0 : (motion_raw_in & feat_on);
  assign db_limit  = 8'(DEBOUNCE);

  // ---------------------------------------------------------------
  // Debounce and output hold
  // ---------------------------------------------------------------
  // A flag passes the filter once it has stood for the debounce
  // count of sample ticks; it drops as soon as the condition goes.
  always_comb
  begin
    for (int i = 0; i < MF_COUNT; i++)
    begin
      db_cnt_nxt[i] = db_cnt_r[i];
      if (!gated_raw[i])
        db_cnt_nxt[i] = '0;
      else if (tick_r && (db_cnt_r[i] < db_limit))
        db_cnt_nxt[i] = db_cnt_r[i] + 8'h01;
      filtered[i] = gated_raw[i] && (db_cnt_r[i] >= db_limit);
    end
  end

  // Raw or filtered source, then optional latching until disabled.
  always_comb
  begin
    chosen    = motion_r[MOT_RAW] ? gated_raw : filtered;
    flags_nxt = chosen;
    if (motion_r[MOT_HOLD])
      flags_nxt = flags_r | chosen;
    flags_nxt = flags_nxt & feat_on;
    if (block_reset)
      flags_nxt = '0;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      flags_r <= '0;
      for (int i = 0; i < MF_COUNT; i++)
        db_cnt_r[i] <= '0;
    end
    else
    begin
      flags_r <= flags_nxt;
      for (int i = 0; i < MF_COUNT; i++)
        db_cnt_r[i] <= db_cnt_nxt[i];
    end
  end

  assign motion_flags_out = flags_r;

  // ---------------------------------------------------------------
  // Output burst tracking
  // ---------------------------------------------------------------
  // The read index only moves after a burst that starts at the
  // first X byte and ends at the last Z byte.
  assign rd_hit_low  = reg_rd_in && (reg_addr_in == ADDR_X_LOW);
  assign rd_hit_high = reg_rd_in && (reg_addr_in == ADDR_Z_HIGH);
  assign rd_in_burst = (reg_addr_in > ADDR_X_LOW) &&
                       (reg_addr_in < ADDR_Z_HIGH);

  always_comb
  begin
    seq_nxt = seq_r;
    qif.pop = 1'b0;
    case (seq_r)
      SEQ_IDLE:
      begin
        if (rd_hit_low)
          seq_nxt = SEQ_ARMED;
      end
      SEQ_ARMED:
      begin
        if (rd_hit_high)
        begin
          qif.pop = 1'b1;
          seq_nxt = SEQ_IDLE;
        end
        else if (reg_rd_in && !rd_in_burst && !rd_hit_low)
          seq_nxt = SEQ_IDLE;
      end
      default:
        seq_nxt = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      seq_r <= SEQ_IDLE;
    else
      seq_r <= seq_nxt;
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Queue flags are sampled live at the read strobe; the motion
  // register is write-only and reads back as zero like any
  // unmapped address.
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (reg_rd_in)
    begin
      rdata_nxt = READ_ZERO;
      case (reg_addr_in)
        ADDR_RATE:
          rdata_nxt = rate_r;
        ADDR_FIFO_FLAGS:
        begin
          rdata_nxt[FLAG_EMPTY] = qif.empty;
          rdata_nxt[FLAG_FULL]  = qif.full;
          rdata_nxt[FLAG_LEVEL] = qif.level_hit;
        end
        ADDR_FIFO_READ:
          rdata_nxt[PTR_W-1:0] = qif.queue_read_index;
        default:
          rdata_nxt = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_r <= READ_ZERO;
    else
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata_out = rdata_r;

endmodule

// >>> accel_regs_props.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port checker for the rate, motion and queue register bank
// ---------------------------------------------------------------
module accel_regs_props
  import accel_regs_pkg::*;
(
  input wire logic                clock_in,
  input wire logic                rst_in,
  input wire logic [7:0]          reg_addr_in,
  input wire logic                reg_wr_in,
  input wire logic [7:0]          reg_wdata_in,
  input wire logic                reg_rd_in,
  input wire logic [7:0]          reg_rdata_out,
  input wire logic                sample_valid_in,
  input wire logic                z_captured_in,
  input wire logic [RATE_W-1:0]   osc_select_out,
  input wire logic                sample_tick_out,
  input wire logic [MF_COUNT-1:0] motion_flags_out,
  input wire logic                motion_reset_out,
  input wire logic                z_polarity_select_out,
  input wire logic [PTR_W-1:0]    queue_write_index_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // Decoded write strobes for the two writable registers, plus the queue sample take.
  wire rate_wr = reg_wr_in && (reg_addr_in == ADDR_RATE);
  wire mot_wr  = reg_wr_in && (reg_addr_in == ADDR_MOTION);
  wire take    = sample_valid_in && z_captured_in;

  a_rate_to_osc: assert property (
    rate_wr |=> osc_select_out == $past(reg_wdata_in[RATE_W-1:0]))
    else $error("oscillator select did not follow rate write");
  a_rate_holds: assert property (
    !rate_wr |=> $stable(osc_select_out))
    else $error("oscillator select changed without a write");
  a_zpol_write: assert property (
    mot_wr |=> z_polarity_select_out == $past(reg_wdata_in[MOT_ZPOL]))
    else $error("z polarity did not follow motion write");
  a_blkrst_write: assert property (
    mot_wr |=> motion_reset_out == $past(reg_wdata_in[MOT_BLKRST]))
    else $error("motion reset did not follow motion write");
  a_blkrst_sticky: assert property (
    motion_reset_out && !mot_wr |=> motion_reset_out)
    else $error("motion reset cleared by itself");
  a_flags_in_reset: assert property (
    motion_reset_out ##1 motion_reset_out |-> motion_flags_out == '0)
    else $error("motion flags active during block reset");
  a_wptr_idle: assert property (
    !take |=> $stable(queue_write_index_out))
    else $error("write index moved without a captured sample");
  a_wptr_step: assert property (
    take |=> (queue_write_index_out == $past(queue_write_index_out) + 6'h01)
          || $stable(queue_write_index_out))
    else $error("write index moved by other than one");
  a_flags_reserved: assert property (
    reg_rd_in && reg_addr_in == ADDR_FIFO_FLAGS
      |=> reg_rdata_out[7:3] == 5'h00)
    else $error("reserved queue flag bits not zero");
  a_index_reserved: assert property (
    reg_rd_in && reg_addr_in == ADDR_FIFO_READ |=> reg_rdata_out[7:6] == 2'h0)
    else $error("reserved read index bits not zero");

  c_rate_write: cover property (rate_wr);
  c_sample_take: cover property (take);
  c_tick_pulse: cover property (sample_tick_out ##1 !sample_tick_out);
endmodule

bind accel_rate_motion_fifo_regs accel_regs_props accel_regs_props_i (
  .clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .sample_valid_in(sample_valid_in),
  .z_captured_in(z_captured_in), .osc_select_out(osc_select_out),
  .sample_tick_out(sample_tick_out), .motion_flags_out(motion_flags_out),
  .motion_reset_out(motion_reset_out),
  .z_polarity_select_out(z_polarity_select_out),
  .queue_write_index_out(queue_write_index_out));

// >>> host_bus_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host processor issuing single-byte register accesses
// ---------------------------------------------------------------
module host_bus_model
  import accel_regs_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic [7:0] reg_rdata_in,
  output logic      [7:0] reg_addr_out,
  output logic            reg_wr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            reg_rd_out
);
  // Bus starts idle before the first edge.
  initial
  begin
    reg_addr_out  = 8'h00;
    reg_wr_out    = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out    = 1'b0;
  end

  // One write; released data is inverted so stale values never match.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock_in);
    reg_addr_out  <= addr;
    reg_wdata_out <= data;
    reg_wr_out    <= 1'b1;
    @(posedge clock_in);
    reg_wr_out    <= 1'b0;
    reg_wdata_out <= ~data;
  endtask

  // One read; data is taken once the registered answer has settled.
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clock_in);
    reg_addr_out <= addr;
    reg_rd_out   <= 1'b1;
    @(posedge clock_in);
    reg_rd_out   <= 1'b0;
    reg_addr_out <= ~addr;
    #1;
    data = reg_rdata_in;
  endtask

  // Rate writes always carry zeros above and the mandatory one in bit 3.
  task automatic write_rate(input logic [2:0] code);
    write_reg(ADDR_RATE, {5'h01, code});
  endtask

  // Shake or tilt-35 pull in any-motion unless told to misbehave.
  task automatic write_motion(input logic [7:0] v, input logic keep);
    logic [7:0] w;
    w = v;
    if (keep && (v[MOT_SHAKE] || v[MOT_T35]))
      w[MOT_ANY_ON] = 1'b1;
    write_reg(ADDR_MOTION, w);
  endtask

  // Full output burst from the first X byte to the last Z byte.
  task automatic pop_burst();
    logic [7:0] d;
    for (int a = ADDR_X_LOW; a <= ADDR_Z_HIGH; a++)
      read_reg(a[7:0], d);
  endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  import accel_regs_pkg::*;
  localparam int CLK_TB = 100_000;
  localparam int DEB_TB = 2;
  logic          clock_in;
  logic          rst_in;
  logic [7:0]    reg_addr;
  logic          reg_wr;
  logic [7:0]    reg_wdata;
  logic          reg_rd;
  logic [7:0]    reg_rdata;
  logic          sample_valid;
  logic          z_captured;
  logic [4:0]    motion_raw;
  logic [2:0]    osc_select;
  logic          sample_tick;
  logic [4:0]    motion_flags;
  logic          motion_reset;
  logic          z_pol;
  logic [5:0]    wr_index;
  logic [7:0]    d;
  int            n;
  int            fill;
  int            num_errors;
  int            samples_checked;
  logic [7:0]    ctl [4] = '{8'h41, 8'h58, 8'h5C, 8'h40};
  logic [4:0]    msk [4] = '{5'h03, 5'h00, 5'h1C, 5'h00};

  accel_rate_motion_fifo_regs #(.CLK_HZ(CLK_TB), .DEBOUNCE(DEB_TB))
    accel_rate_motion_fifo_regs_i (
    .clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
    .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .sample_valid_in(sample_valid),
    .z_captured_in(z_captured), .motion_raw_in(motion_raw),
    .osc_select_out(osc_select), .sample_tick_out(sample_tick),
    .motion_flags_out(motion_flags), .motion_reset_out(motion_reset),
    .z_polarity_select_out(z_pol), .queue_write_index_out(wr_index));
  host_bus_model host_bus_model_i (
    .clock_in(clock_in), .reg_rdata_in(reg_rdata), .reg_addr_out(reg_addr),
    .reg_wr_out(reg_wr), .reg_wdata_out(reg_wdata), .reg_rd_out(reg_rd));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Sample period in cycles for each rate code.
  function automatic int exp_period(input int r);
    int hz [8] = '{50, 100, 125, 200, 250, 500, 1000, 2000};
    return CLK_TB / hz[r];
  endfunction

  // Queue flag byte for a given fill level.
  function automatic logic [7:0] exp_flags(input int f);
    return {5'h00, f >= LEVEL_DEFAULT, f == QUEUE_DEPTH, f == 0};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp,
                       input string what);
    host_bus_model_i.read_reg(a, d);
    chk(16'(d), exp, what);
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge clock_in);
    #1;
  endtask

  // Counts cycles up to the next tick, bounded.
  task automatic wait_tick(output int c);
    c = 0;
    do
    begin
      @(posedge clock_in);
      #1;
      c++;
    end while (sample_tick !== 1'b1 && c < 5000);
  endtask

  task automatic push(input logic z);
    @(posedge clock_in);
    sample_valid <= 1'b1;
    z_captured   <= z;
    @(posedge clock_in);
    sample_valid <= 1'b0;
    z_captured   <= ~z;
    #1;
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ---------------------------------------------------------------
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // Cuts a hang short well beyond the expected run time.
  initial
  begin
    #400_000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end

  initial
  begin
    num_errors = 0;
    samples_checked = 0;
    rst_in = 1'b1;
    sample_valid = 1'b0;
    z_captured = 1'b0;
    motion_raw = 5'h00;
    void'($urandom(32'hB797BD29));
    repeat (16) @(posedge clock_in);
    rst_in <= 1'b0;
    rdchk(ADDR_RATE, 16'h00, "rate reset");
    rdchk(ADDR_MOTION, 16'h00, "motion write-only");
    rdchk(ADDR_FIFO_FLAGS, 16'h01, "flags reset");
    rdchk(ADDR_FIFO_READ, 16'h00, "read index reset");
    rdchk(8'h3F, 16'h00, "unmapped read");
    host_bus_model_i.write_reg(ADDR_FIFO_FLAGS, 8'hFF);
    rdchk(ADDR_FIFO_FLAGS, 16'h01, "flags read-only");
    $display("test reset done");
    for (int r = 0; r < 8; r++)
    begin
      host_bus_model_i.write_rate(r[2:0]);
      rdchk(ADDR_RATE, {8'h00, 5'h01, r[2:0]}, "rate readback");
      chk(16'(osc_select), 16'(r), "oscillator select");
      wait_tick(n);
      wait_tick(n);
      wait_tick(n);
      chk(16'(n), 16'(exp_period(r)), "tick period");
    end
    $display("test rates done");
    for (int j = 0; j < 4; j++)
    begin
      host_bus_model_i.write_motion(ctl[j], j != 1);
      for (int k = 0; k < 8; k++)
      begin
        @(posedge clock_in);
        motion_raw <= 5'($urandom);
        settle(2);
        chk(16'(motion_flags), 16'(motion_raw & msk[j]),
            "gating");
      end
    end
    @(posedge clock_in);
    motion_raw <= 5'h00;
    host_bus_model_i.write_motion(8'h43, 1'b1);
    motion_raw <= 5'h01;
    @(posedge clock_in);
    motion_raw <= 5'h00;
    settle(4);
    chk(16'(motion_flags), 16'h01, "latched tilt");
    host_bus_model_i.write_motion(8'h41, 1'b1);
    settle(2);
    chk(16'(motion_flags), 16'h00, "latch released");
    host_bus_model_i.write_motion(8'hC1, 1'b1);
    motion_raw <= 5'h1F;
    settle(20);
    chk(16'(motion_reset), 16'h01, "block reset held");
    chk(16'(motion_flags), 16'h00, "flags in reset");
    host_bus_model_i.write_motion(8'h41, 1'b1);
    settle(2);
    chk({15'h0, motion_reset}, 16'h00, "block reset released");
    chk(16'(motion_flags), 16'h03, "flags after reset");
    host_bus_model_i.write_motion(8'h20, 1'b1);
    settle(1);
    chk(16'(z_pol), 16'h01, "z polarity bottom");
    motion_raw <= 5'h00;
    host_bus_model_i.write_motion(8'h01, 1'b1);
    motion_raw <= 5'h01;
    settle(2);
    chk(16'(motion_flags), 16'h00, "debounce pending");
    settle((DEB_TB + 1) * exp_period(7) + 5);
    chk(16'(motion_flags), 16'h01, "debounced tilt");
    chk(16'(z_pol), 16'h00, "z polarity top");
    $display("test motion done");
    push(1'b0);
    chk(16'(wr_index), 16'h00, "uncaptured sample");
    for (int i = 1; i <= QUEUE_DEPTH + 1; i++)
    begin
      push(1'b1);
      fill = (i > QUEUE_DEPTH) ? QUEUE_DEPTH : i;
      chk(16'(wr_index), 16'(fill), "write index");
      rdchk(ADDR_FIFO_FLAGS, 16'(exp_flags(fill)), "fill");
    end
    host_bus_model_i.read_reg(ADDR_X_LOW, d);
    host_bus_model_i.read_reg(ADDR_FIFO_READ, d);
    host_bus_model_i.read_reg(ADDR_Z_HIGH, d);
    rdchk(ADDR_FIFO_READ, 16'h00, "broken burst");
    for (int i = 1; i <= QUEUE_DEPTH; i++)
    begin
      host_bus_model_i.pop_burst();
      rdchk(ADDR_FIFO_READ, 16'(i), "read index");
      rdchk(ADDR_FIFO_FLAGS, 16'(exp_flags(QUEUE_DEPTH - i)),
            "drain");
    end
    $display("test queue done");
    wrap_up();
  end
endmodule
